// ==== include/uctl_consts.vh ====
// How it works
// - five interrupt sources gated by four mask bits
// - mask bit 5 special mode, 4/6/7 zero
// - source register reports highest pending code only
// - source bit 0 low when interrupt pending
// - source bits 7:6 show queue enable
// - time-out only in queue mode, nonempty
// - time-out restarts on stop centre, data read
// - time-out after 4 x length + 12 bits
// - one bit enables both queues together
// - clear bits empty queues, then self-clear
// - ready mode 0: empty/holding based pins
// - ready mode 1: full, trigger or time-out
// - trigger level 1, 4, 8 or 14
// - data length five to eight bits
// - one, one-and-half or two stop bits
// - optional odd or even parity
// - forced parity one or zero
// - break holds transmit line low, except in loop-back
// - divisor access replaces low registers
// - interrupt pin driven only when enabled
// - loop-back: transmit high, internal feedback
// - power-down needs special mode bit also set
`ifndef UCTL_CONSTS_VH
`define UCTL_CONSTS_VH
`define UCTL_IDX_DATA 3'h0
`define UCTL_IDX_MASK 3'h1
`define UCTL_IDX_SRC 3'h2
`define UCTL_IDX_FMT 3'h3
`define UCTL_IDX_MODEM 3'h4
`define UCTL_MASK_RST 8'h00
`define UCTL_FMT_RST 8'h00
`define UCTL_MODEM_RST 8'h00
`define UCTL_DIV_RST 16'h0000
`define UCTL_MASK_WMASK 8'h2F
`define UCTL_MODEM_WMASK 8'h9F
`define UCTL_SRC_NONE 4'h1
`define UCTL_SRC_LINE 4'h6
`define UCTL_SRC_RDA 4'h4
`define UCTL_SRC_TMO 4'hC
`define UCTL_SRC_THRE 4'h2
`define UCTL_SRC_MODEM 4'h0
`define UCTL_Q_EN 0
`define UCTL_Q_RXCLR 1
`define UCTL_Q_TXCLR 2
`define UCTL_Q_MODE 3
`define UCTL_FMT_STOP 2
`define UCTL_FMT_PEN 3
`define UCTL_FMT_EVEN 4
`define UCTL_FMT_STICK 5
`define UCTL_FMT_BRK 6
`define UCTL_FMT_DIV 7
`define UCTL_MO_DTR 0
`define UCTL_MO_RTS 1
`define UCTL_MO_OUT2 2
`define UCTL_MO_INTEN 3
`define UCTL_MO_LOOP 4
`define UCTL_MO_PD 7
`define UCTL_MK_SPECIAL 5
`define UCTL_TMO_MUL 6'h04
`define UCTL_TMO_ADD 6'h0C
`define UCTL_QDEPTH 5'h10
`endif

// ==== core/uctl_top.v ====
`timescale 1ns/100ps
`include "uctl_consts.vh"
module uctl_top
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire [7:0] rx_data_i,
  output reg rx_pop_o,
  output reg tx_push_o,
  output reg [7:0] tx_data_o,
  input wire [4:0] rx_count_i,
  input wire [4:0] tx_count_i,
  input wire tx_shift_busy_i,
  input wire rx_stop_mid_i,
  input wire bit_tick_i,
  input wire line_status_i,
  input wire modem_delta_i,
  input wire tx_serial_i,
  input wire serial_rx_i,
  input wire cts_n_i,
  input wire dsr_n_i,
  input wire bell_indicator_n_i,
  input wire carrier_detect_n_i,
  output reg serial_tx_o,
  output reg rx_serial_o,
  output reg [3:0] modem_in_o,
  output reg dtr_n_o,
  output reg rts_n_o,
  output reg int_o,
  output reg int_oe_o,
  output reg tx_request_n_o,
  output reg rx_request_n_o,
  output reg fifo_en_o,
  output reg rx_fifo_clear_o,
  output reg tx_fifo_clear_o,
  output reg [1:0] word_len_o,
  output reg two_stop_o,
  output reg parity_en_o,
  output reg even_parity_o,
  output reg stick_parity_o,
  output reg [15:0] divisor_o,
  output reg power_down_o,
  output reg rx_timeout_o
);

// ---------------------------------------------
// helpers
// ---------------------------------------------
function [4:0] trig_level;
  input [1:0] sel;
  begin
    case (sel)
      2'h0: trig_level = 5'h01;
      2'h1: trig_level = 5'h04;
      2'h2: trig_level = 5'h08;
      default: trig_level = 5'h0E;
    endcase
  end
endfunction

function [5:0] tmo_bits;
  input [1:0] wl;
  begin
    // 5..8 data bits from the two length bits
    tmo_bits = `UCTL_TMO_MUL * ({4'h0, wl} + 6'h05)
      + `UCTL_TMO_ADD;
  end
endfunction

// ---------------------------------------------
// registers
// ---------------------------------------------
reg [7:0] mask_q;
reg [7:0] fmt_q;
reg [7:0] modem_q;
reg [15:0] div_q;
reg q_en_q;
reg q_mode_q;
reg [1:0] trig_q;
reg thre_q;
reg tx_empty_q;
reg [5:0] tmo_cnt_q;
reg tmo_q;
reg rx_req_q;

// a request held while ack stands is not taken again
wire bus_req = cyc_i & stb_i & ~ack_o;
wire bus_wr = bus_req & we_i & sel_i[0];
wire bus_rd = bus_req & ~we_i;
wire [2:0] idx = adr_i[4:2];
wire dlab = fmt_q[`UCTL_FMT_DIV];
wire loop = modem_q[`UCTL_MO_LOOP];

// ---------------------------------------------
// interrupt priority
// ---------------------------------------------
wire tx_empty = (tx_count_i == 5'h00);
wire rx_nonempty = (rx_count_i != 5'h00);
wire rx_trig = q_en_q ? (rx_count_i >= trig_level(trig_q))
  : rx_nonempty;
wire p_line = mask_q[2] & line_status_i;
wire p_rda = mask_q[0] & rx_trig;
wire p_tmo = mask_q[0] & tmo_q;
wire p_thre = mask_q[1] & thre_q;
wire p_modem = mask_q[3] & modem_delta_i;
reg [3:0] src_code;

always @*
begin
  // one code only, highest source wins
  if (p_line)
    src_code = `UCTL_SRC_LINE;
  else if (p_rda)
    src_code = `UCTL_SRC_RDA;
  else if (p_tmo)
    src_code = `UCTL_SRC_TMO;
  else if (p_thre)
    src_code = `UCTL_SRC_THRE;
  else if (p_modem)
    src_code = `UCTL_SRC_MODEM;
  else
    src_code = `UCTL_SRC_NONE;
end

wire any_pend = ~src_code[0];
wire [7:0] src_reg = {q_en_q, q_en_q, 2'h0, src_code};

// ---------------------------------------------
// read mux
// ---------------------------------------------
reg [7:0] rd_byte;
// divisor access hides the data and mask reads

always @*
begin
  case (idx)
    `UCTL_IDX_DATA: rd_byte = dlab ? div_q[7:0] : rx_data_i;
    `UCTL_IDX_MASK: rd_byte = dlab ? div_q[15:8] : mask_q;
    `UCTL_IDX_SRC: rd_byte = src_reg;
    `UCTL_IDX_FMT: rd_byte = fmt_q;
    `UCTL_IDX_MODEM: rd_byte = modem_q;
    default: rd_byte = 8'h00;
  endcase
end

wire rd_data = bus_rd & (idx == `UCTL_IDX_DATA) & ~dlab;
wire rd_src = bus_rd & (idx == `UCTL_IDX_SRC);
wire wr_data = bus_wr & (idx == `UCTL_IDX_DATA) & ~dlab;

// ---------------------------------------------
// bus slave and control registers
// ---------------------------------------------
always @(posedge clk_i)
begin
  if (rst_i)
  begin
    ack_o <= 1'b0;
    dat_o <= 32'h0000_0000;
    mask_q <= `UCTL_MASK_RST;
    fmt_q <= `UCTL_FMT_RST;
    modem_q <= `UCTL_MODEM_RST;
    div_q <= `UCTL_DIV_RST;
    q_en_q <= 1'b0;
    q_mode_q <= 1'b0;
    trig_q <= 2'h0;
    rx_fifo_clear_o <= 1'b0;
    tx_fifo_clear_o <= 1'b0;
    rx_pop_o <= 1'b0;
    tx_push_o <= 1'b0;
    tx_data_o <= 8'h00;
  end
  else if (ce_i)
  begin
    // one wait state: ack a cycle after the strobe
    ack_o <= bus_req;
    dat_o <= bus_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    rx_pop_o <= rd_data;
    tx_push_o <= wr_data;
    rx_fifo_clear_o <= 1'b0;
    tx_fifo_clear_o <= 1'b0;
    if (wr_data)
      tx_data_o <= dat_i[7:0];
    // queue control shares the source index, reads see source
    if (bus_wr)
    begin
      case (idx)
        `UCTL_IDX_DATA:
          if (dlab)
            div_q[7:0] <= dat_i[7:0];
        `UCTL_IDX_MASK:
          if (dlab)
            div_q[15:8] <= dat_i[7:0];
          else
            mask_q <= dat_i[7:0] & `UCTL_MASK_WMASK;
        `UCTL_IDX_SRC:
        begin
          q_en_q <= dat_i[`UCTL_Q_EN];
          q_mode_q <= dat_i[`UCTL_Q_MODE];
          trig_q <= dat_i[7:6];
          // strobes only; shift registers are elsewhere
          rx_fifo_clear_o <= dat_i[`UCTL_Q_RXCLR];
          tx_fifo_clear_o <= dat_i[`UCTL_Q_TXCLR];
        end
        `UCTL_IDX_FMT: fmt_q <= dat_i[7:0];
        `UCTL_IDX_MODEM:
          modem_q <= dat_i[7:0] & `UCTL_MODEM_WMASK;
        default: ;
      endcase
    end
  end
end

// ---------------------------------------------
// holding-empty interrupt and time-out
// ---------------------------------------------
wire tmo_restart = rx_stop_mid_i | rd_data | rx_fifo_clear_o;
wire tmo_arm = q_en_q & rx_nonempty;
wire [5:0] tmo_limit = tmo_bits(fmt_q[1:0]);

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    thre_q <= 1'b0;
    tx_empty_q <= 1'b1;
    tmo_cnt_q <= 6'h00;
    tmo_q <= 1'b0;
  end
  else if (ce_i)
  begin
    tx_empty_q <= tx_empty;
    // a new empty edge wins over the read that clears it
    if (tx_empty & ~tx_empty_q)
      thre_q <= 1'b1;
    else if (wr_data | (rd_src & src_code == `UCTL_SRC_THRE))
      thre_q <= 1'b0;
    if (tmo_restart | ~tmo_arm)
    begin
      tmo_cnt_q <= 6'h00;
      tmo_q <= 1'b0;
    end
    // counting stops at the flag until a restart
    else if (bit_tick_i & ~tmo_q)
    begin
      tmo_cnt_q <= tmo_cnt_q + 6'h01;
      if (tmo_cnt_q + 6'h01 >= tmo_limit)
        tmo_q <= 1'b1;
    end
  end
end

// ---------------------------------------------
// request pins
// ---------------------------------------------
wire mode1 = q_en_q & q_mode_q;

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    tx_request_n_o <= 1'b0;
    rx_request_n_o <= 1'b1;
    rx_req_q <= 1'b0;
  end
  else if (ce_i)
  begin
    if (mode1)
    begin
      // full-only stall, else one or more free
      tx_request_n_o <= (tx_count_i == `UCTL_QDEPTH);
      if (~rx_nonempty)
        rx_req_q <= 1'b0;
      else if (rx_count_i >= trig_level(trig_q) | tmo_q)
        rx_req_q <= 1'b1;
    end
    else
    begin
      // busy shifter alone does not hold it high
      tx_request_n_o <= ~tx_empty;
      rx_req_q <= rx_nonempty;
    end
    rx_request_n_o <= ~(mode1 ? (rx_req_q & rx_nonempty)
      : rx_nonempty);
  end
end

// ---------------------------------------------
// line side
// ---------------------------------------------
always @(posedge clk_i)
begin
  if (rst_i)
  begin
    serial_tx_o <= 1'b1;
    rx_serial_o <= 1'b1;
    modem_in_o <= 4'h0;
    dtr_n_o <= 1'b1;
    rts_n_o <= 1'b1;
    int_o <= 1'b0;
    int_oe_o <= 1'b0;
    power_down_o <= 1'b0;
  end
  else if (ce_i)
  begin
    if (loop)
      serial_tx_o <= 1'b1;
    else if (fmt_q[`UCTL_FMT_BRK])
      serial_tx_o <= 1'b0;
    else
      serial_tx_o <= tx_serial_i;
    // break also reaches the looped receiver
    rx_serial_o <= loop ? (tx_serial_i & ~fmt_q[`UCTL_FMT_BRK])
      : serial_rx_i;
    // msb first: carrier, bell, set-ready, clear-to-send
    if (loop)
      modem_in_o <= {modem_q[`UCTL_MO_INTEN], modem_q[`UCTL_MO_OUT2],
        modem_q[`UCTL_MO_DTR], modem_q[`UCTL_MO_RTS]};
    else
      modem_in_o <= ~{carrier_detect_n_i, bell_indicator_n_i,
        dsr_n_i, cts_n_i};
    // pins parked high in loop-back
    dtr_n_o <= loop | ~modem_q[`UCTL_MO_DTR];
    rts_n_o <= loop | ~modem_q[`UCTL_MO_RTS];
    // level kept even while the pin floats
    int_o <= any_pend;
    int_oe_o <= modem_q[`UCTL_MO_INTEN];
    // special mode gate stops a stray power-down write
    power_down_o <= modem_q[`UCTL_MO_PD]
      & mask_q[`UCTL_MK_SPECIAL];
  end
end

// ---------------------------------------------
// format outputs
// ---------------------------------------------
always @(posedge clk_i)
begin
  if (rst_i)
  begin
    fifo_en_o <= 1'b0;
    word_len_o <= 2'h0;
    two_stop_o <= 1'b0;
    parity_en_o <= 1'b0;
    even_parity_o <= 1'b0;
    stick_parity_o <= 1'b0;
    divisor_o <= `UCTL_DIV_RST;
    rx_timeout_o <= 1'b0;
  end
  else if (ce_i)
  begin
    fifo_en_o <= q_en_q;
    word_len_o <= fmt_q[1:0];
    // 1.5 vs 2 decided by length at the shifter
    two_stop_o <= fmt_q[`UCTL_FMT_STOP];
    parity_en_o <= fmt_q[`UCTL_FMT_PEN];
    // parity sense passed on even with parity off
    even_parity_o <= fmt_q[`UCTL_FMT_EVEN];
    stick_parity_o <= fmt_q[`UCTL_FMT_PEN]
      & fmt_q[`UCTL_FMT_STICK];
    divisor_o <= div_q;
    rx_timeout_o <= tmo_q;
  end
end

endmodule

// ==== verif/uctl_checker.sv ====
`timescale 1ns/100ps
module uctl_checker
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire tx_serial_i,
  input wire serial_tx_o,
  input wire dtr_n_o,
  input wire rts_n_o,
  input wire int_o,
  input wire int_oe_o,
  input wire fifo_en_o,
  input wire rx_fifo_clear_o,
  input wire power_down_o
);
  // ----------
  // register shadow
  // ----------
  // taken at the ack edge, so it matches the lagged outputs
  reg [7:0] fmt_q;
  reg [7:0] mod_q;
  reg [7:0] msk_q;
  wire wr = ack_o & cyc_i & stb_i & we_i & sel_i[0];
  wire [2:0] idx = adr_i[4:2];
  wire rd_src = ack_o & !we_i & (idx == 3'h2);
  always @(posedge clk_i)
  begin
    if (rst_i)
      {fmt_q, mod_q, msk_q} <= 24'h000000;
    else if (wr && idx == 3'h3)
      fmt_q <= dat_i[7:0];
    else if (wr && idx == 3'h4)
      mod_q <= dat_i[7:0];
    else if (wr && idx == 3'h1 && !fmt_q[7])
      msk_q <= dat_i[7:0];
  end
  // ----------
  // properties
  // ----------
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_once:
  assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse after request");
  a_break_low:
  assert property (!$past(rst_i) && $past(ce_i) |-> serial_tx_o ==
    (mod_q[4] | (!fmt_q[6] & $past(tx_serial_i))))
    else $error("transmit pin wrong");
  a_dtr_rts:
  assert property ({dtr_n_o, rts_n_o} ==
    (mod_q[4] ? 2'h3 : ~{mod_q[0], mod_q[1]}))
    else $error("modem outputs wrong");
  a_int_pin:
  assert property (int_oe_o == mod_q[3])
    else $error("interrupt pin enable wrong");
  a_pd_gate:
  assert property (power_down_o == (mod_q[7] & msk_q[5]))
    else $error("power down gating wrong");
  a_int_masked:
  assert property (msk_q[3:0] == 4'h0 |-> !int_o)
    else $error("interrupt with all sources masked");
  a_src_code:
  assert property (rd_src |-> (dat_o[3:0] inside
    {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hC}) && (fifo_en_o || !dat_o[3]))
    else $error("bad source code");
  a_src_top:
  assert property (rd_src |-> dat_o[7:4] == {fifo_en_o, fifo_en_o, 2'h0})
    else $error("source upper bits wrong");
  a_clear_self:
  assert property (rx_fifo_clear_o |=> !rx_fifo_clear_o)
    else $error("queue clear not self clearing");
  c_pending: cover property (rd_src && !dat_o[0]);
  c_power: cover property (power_down_o);
  c_irq: cover property (int_o && int_oe_o);
endmodule
bind uctl_top uctl_checker chk_i
(
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .tx_serial_i(tx_serial_i),
  .serial_tx_o(serial_tx_o), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
  .int_o(int_o), .int_oe_o(int_oe_o), .fifo_en_o(fifo_en_o),
  .rx_fifo_clear_o(rx_fifo_clear_o), .power_down_o(power_down_o)
);

// ==== verif/uctl_modem_model.sv ====
`timescale 1ns/100ps
module uctl_modem_model
#(
  parameter LAG = 1
)
(
  input wire clk_i,
  input wire dtr_n_i,
  input wire rts_n_i,
  input wire serial_tx_i,
  output reg cts_n_o,
  output reg dsr_n_o,
  output reg cd_n_o,
  output reg ri_n_o,
  output reg serial_rx_o
);
  // ----------
  // remote modem
  // ----------
  // clear-to-send answers late on purpose; LAG up to 8
  reg [7:0] rts_q;
  initial {rts_q, cts_n_o, dsr_n_o, cd_n_o, ri_n_o, serial_rx_o} = 13'h1FFF;
  always @(posedge clk_i)
  begin
    rts_q <= {rts_q[6:0], rts_n_i};
    cts_n_o <= rts_q[LAG-1];
    dsr_n_o <= dtr_n_i;
    cd_n_o <= dtr_n_i;
    ri_n_o <= 1'h1;
    serial_rx_o <= serial_tx_i;
  end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  reg clk = 1'h0;
  reg rst = 1'h1;
  reg cyc = 1'h0;
  reg stb = 1'h0;
  reg we = 1'h0;
  reg ce = 1'h1;
  reg txs = 1'h1;
  reg tick = 1'h0;
  reg smid = 1'h0;
  reg ls = 1'h0;
  reg md = 1'h0;
  reg [4:0] adr = 5'h00;
  reg [4:0] rxc = 5'h00;
  reg [4:0] txc = 5'h00;
  reg [7:0] rxd = 8'h00;
  reg [7:0] rd;
  reg [31:0] wd = 32'h0;
  reg [19:0] lvs = 20'h0910E;
  integer fails = 0;
  integer n_tests = 0;
  integer cnt = 0;
  integer n_pop, n_push, n_rclr, n_tclr;
  integer i;
  wire ack, stx, dtr, rts, irq, ioe, txr, rxr, pd, tmo;
  wire cts, dsr, ri, cd, srx;
  wire [3:0] mi;
  wire [15:0] dv;
  wire [31:0] dat;
  wire fen, rclr, tclr, ts, pe, ep, sp, pop, push, rxs;
  wire [1:0] wl;
  wire [7:0] txd;
  uctl_top uut
  (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(dat),
    .ack_o(ack), .rx_data_i(rxd), .rx_pop_o(pop), .tx_push_o(push),
    .tx_data_o(txd), .rx_count_i(rxc), .tx_count_i(txc),
    .tx_shift_busy_i(1'h0), .rx_stop_mid_i(smid), .bit_tick_i(tick),
    .line_status_i(ls), .modem_delta_i(md), .tx_serial_i(txs),
    .serial_rx_i(srx), .cts_n_i(cts), .dsr_n_i(dsr),
    .bell_indicator_n_i(ri), .carrier_detect_n_i(cd),
    .serial_tx_o(stx), .rx_serial_o(rxs), .modem_in_o(mi),
    .dtr_n_o(dtr), .rts_n_o(rts), .int_o(irq), .int_oe_o(ioe),
    .tx_request_n_o(txr), .rx_request_n_o(rxr), .fifo_en_o(fen),
    .rx_fifo_clear_o(rclr), .tx_fifo_clear_o(tclr), .word_len_o(wl),
    .two_stop_o(ts), .parity_en_o(pe), .even_parity_o(ep),
    .stick_parity_o(sp), .divisor_o(dv), .power_down_o(pd),
    .rx_timeout_o(tmo)
  );
  uctl_modem_model #(.LAG(3)) modem
  (
    .clk_i(clk), .dtr_n_i(dtr), .rts_n_i(rts), .serial_tx_i(stx),
    .cts_n_o(cts), .dsr_n_o(dsr), .cd_n_o(cd), .ri_n_o(ri),
    .serial_rx_o(srx)
  );
  // ----------
  // helpers
  // ----------
  initial forever #5 clk = ~clk;
  task give_verdict;
  begin
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // hang guard; the whole run needs about 320 cycles
  always @(posedge clk)
  begin
    cnt <= cnt + 1;
    if (cnt == 20000)
    begin
      fails = fails + 1;
      give_verdict;
    end
  end
  // pulse counters, cleared by reset
  always @(posedge clk)
  begin
    if (rst)
    begin
      n_pop <= 0;
      n_push <= 0;
      n_rclr <= 0;
      n_tclr <= 0;
    end
    else
    begin
      n_pop <= n_pop + pop;
      n_push <= n_push + push;
      n_rclr <= n_rclr + rclr;
      n_tclr <= n_tclr + tclr;
    end
  end
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input [31:0] s, input [31:0] e);
  begin
    n_tests = n_tests + 1;
    if (s !== e)
    begin
      fails = fails + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, s, e);
    end
  end
  endtask
  task bus(input w, input [4:0] a, input [7:0] d);
  begin
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'h1)
      @(posedge clk);
    rd = dat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    wt(1);
  end
  endtask
  task rchk(input [4:0] a, input [7:0] e);
  begin
    bus(1'h0, a, 8'h00);
    chk(rd, e);
  end
  endtask
  task ticks(input integer n);
    repeat (n)
    begin
      tick <= 1'h1;
      wt(1);
      tick <= 1'h0;
      wt(1);
    end
  endtask
  // ----------
  // scenarios
  // ----------
  task t_prio;
  begin
    rchk(5'h08, 8'h01);
    chk({stx, txr, rxr, ioe}, 4'hA);
    bus(1'h1, 5'h04, 8'h0F);
    ls <= 1'h1;
    md <= 1'h1;
    rxc <= 5'h01;
    wt(3);
    chk(irq, 1'h1);
    rchk(5'h08, 8'h06);
    ls <= 1'h0;
    wt(3);
    rchk(5'h08, 8'h04);
    rxc <= 5'h00;
    txc <= 5'h01;
    wt(3);
    txc <= 5'h00;
    wt(3);
    rchk(5'h08, 8'h02);
    rchk(5'h08, 8'h00);
    md <= 1'h0;
    bus(1'h1, 5'h04, 8'h00);
    wt(3);
    chk(irq, 1'h0);
  end
  endtask
  task t_trig;
  begin
    bus(1'h1, 5'h04, 8'h0F);
    bus(1'h1, 5'h08, 8'h01);
    for (i = 0; i < 4; i = i + 1)
    begin
      bus(1'h1, 5'h08, {i[1:0], 6'h07});
      rxc <= lvs[15-5*i +: 5] - 5'h01;
      wt(3);
      rchk(5'h08, 8'hC1);
      rxc <= lvs[15-5*i +: 5];
      wt(3);
      rchk(5'h08, 8'hC4);
    end
  end
  endtask
  task t_tmo;
  begin
    rxc <= 5'h00;
    bus(1'h1, 5'h0C, 8'h03);
    bus(1'h1, 5'h08, 8'hC9);
    rxc <= 5'h01;
    wt(3);
    chk(rxr, 1'h1);
    ticks(43);
    wt(3);
    chk(tmo, 1'h0);
    ticks(1);
    wt(3);
    chk({tmo, rxr}, 2'h2);
    rchk(5'h08, 8'hCC);
    smid <= 1'h1;
    wt(1);
    smid <= 1'h0;
    wt(3);
    chk({tmo, rxr}, 2'h0);
    rxc <= 5'h00;
    txc <= 5'h10;
    wt(3);
    chk({rxr, txr}, 2'h3);
    txc <= 5'h0F;
    wt(3);
    chk(txr, 1'h0);
    bus(1'h1, 5'h08, 8'h00);
    rxc <= 5'h01;
    wt(3);
    chk({txr, rxr}, 2'h2);
  end
  endtask
  task t_line;
  begin
    bus(1'h1, 5'h0C, 8'h43);
    wt(2);
    chk(stx, 1'h0);
    bus(1'h1, 5'h10, 8'h0B);
    wt(6);
    chk({dtr, rts, ioe, mi}, 7'h1B);
    bus(1'h1, 5'h10, 8'h19);
    wt(3);
    chk({stx, dtr, rts, mi}, 7'h7A);
  end
  endtask
  task t_regs;
  begin
    bus(1'h1, 5'h10, 8'h80);
    wt(2);
    chk(pd, 1'h0);
    bus(1'h1, 5'h04, 8'hFF);
    rchk(5'h04, 8'h2F);
    chk(pd, 1'h1);
    bus(1'h1, 5'h0C, 8'h83);
    bus(1'h1, 5'h00, 8'h34);
    bus(1'h1, 5'h04, 8'h12);
    wt(2);
    chk(dv, 16'h1234);
    bus(1'h1, 5'h0C, 8'h03);
    rxd <= 8'h5A;
    rchk(5'h04, 8'h2F);
    rchk(5'h00, 8'h5A);
    rchk(5'h1C, 8'h00);
  end
  endtask
  task t_fmt;
  begin
    rst <= 1'h1;
    wt(2);
    chk({stx, dtr, rts, ioe, txr, rxr, pd, irq}, 8'hE4);
    rst <= 1'h0;
    wt(1);
    ce <= 1'h0;
    txs <= 1'h0;
    wt(3);
    chk(stx, 1'h1);
    ce <= 1'h1;
    wt(4);
    chk({stx, rxs}, 2'h0);
    bus(1'h1, 5'h0C, 8'h3C);
    chk({wl, ts, pe, ep, sp}, 6'h0F);
    bus(1'h1, 5'h0C, 8'h33);
    chk({wl, ts, pe, ep, sp}, 6'h32);
    bus(1'h1, 5'h08, 8'h07);
    chk({fen, n_rclr[3:0], n_tclr[3:0]}, 9'h111);
    bus(1'h1, 5'h00, 8'hA5);
    rchk(5'h00, 8'h5A);
    chk({txd, n_push[3:0], n_pop[3:0]}, 16'hA511);
    bus(1'h1, 5'h10, 8'h10);
    wt(2);
    chk({stx, rxs}, 2'h2);
    txs <= 1'h1;
    wt(2);
    chk({stx, rxs}, 2'h3);
  end
  endtask
  initial
  begin
    wt(10);
    rst <= 1'h0;
    wt(1);
    t_prio;
    t_trig;
    t_tmo;
    t_line;
    t_regs;
    t_fmt;
    give_verdict;
  end
endmodule
